// ---- logic/pir_consts.svh ----
// constants for the processor identification register bank
`ifndef PIR_CONSTS_SVH
`define PIR_CONSTS_SVH

// coprocessor read encoding: opcode1, primary, secondary, opcode2
`define PIR_OPC1_ID        3'h0
`define PIR_CRN_ID         4'h0
`define PIR_CRM_MAIN       4'h0
`define PIR_CRM_FEAT       4'h1
`define PIR_OPC2_TCM       3'h2
`define PIR_OPC2_TLB       3'h3
`define PIR_OPC2_AFF       3'h5
`define PIR_OPC2_PFR0      3'h0
`define PIR_OPC2_PFR1      3'h1
`define PIR_OPC2_DFR0      3'h2
`define PIR_OPC2_AFR0      3'h3

// affinity register field positions and fixed values
`define PIR_AFF_FMT_BIT    31
`define PIR_AFF_UP_BIT     30
`define PIR_AFF_CL_LSB     8
`define PIR_AFF_FMT_VAL    1'h1
`define PIR_AFF_UP_VAL     1'h0

// processor feature register 0 fields
`define PIR_PFR0_ST3       4'h1
`define PIR_PFR0_ST2       4'h2
`define PIR_PFR0_ST1       4'h3
`define PIR_PFR0_ST0       4'h1
// processor feature register 1 fields
`define PIR_PFR1_MPROF     4'h0
`define PIR_PFR1_SEC       4'h1
`define PIR_PFR1_PM        4'h1
// debug feature register fields
`define PIR_DFR_PMU        4'h2
`define PIR_DFR_MDBG_M     4'h0
`define PIR_DFR_MMTRC      4'h1
`define PIR_DFR_CPTRC      4'h0
`define PIR_DFR_MMDBG      4'h4
`define PIR_DFR_CPSDBG     4'h4
`define PIR_DFR_CPDBG      4'h4

// reset value of the read data and of the sampled straps
`define PIR_ZERO32         32'h0000_0000
`define PIR_ZERO4          4'h0
`define PIR_ZERO2          2'h0

`endif

// ---- logic/pir_pkg.sv ----
// types for the processor identification register bank
`default_nettype none
package pir_pkg;

  // which identification register a request selects
  typedef enum logic [3:0] {
    PIR_SEL_NONE,
    PIR_SEL_TCM,
    PIR_SEL_TLB,
    PIR_SEL_AFF,
    PIR_SEL_PFR0,
    PIR_SEL_PFR1,
    PIR_SEL_DFR0,
    PIR_SEL_AFR0
  } pir_sel_type;

endpackage
`default_nettype wire

// ---- logic/pir_regs.sv ----
// processor identification register bank behind the coprocessor read port
// Functional notes
// R1: tightly coupled memory type register always reads zero.
// R2: tlb type register always reads zero, no lockable entries.
// R3: affinity, feature 1 and debug feature registers need privileged mode.
// R4: one copy of each register; secure and non-secure read the same.
// R5: affinity bit 31 always reads one, new multiprocessor format.
// R6: affinity bit 30 reads zero, core is always multiprocessor.
// R7: affinity bits 11:8 return the sampled cluster number pins.
// R8: affinity bits 1:0 return the core index, 0 to 3.
// R9: opcode1 0, c0, c0, opcode2 5 reads the affinity register.
// R10: c0, c1, opcode2 0..3 read feature 0, feature 1, debug, auxiliary.
// R11: feature 0 bits 15:12 read 1, bits 11:8 read 2.
// R12: feature 0 bits 31:16 zero, 7:4 read 3, 3:0 read 1.
// R13: feature 1 bits 31:8 zero, 7:4 read 1, 3:0 read 1.
// R14: debug bits 31:28, 23:20, 15:12 zero; 27:24 two; 19:16 one.
// R15: debug bits 11:8, 7:4 and 3:0 each read four.
// R16: auxiliary register reads all zero and ignores writes.
// R17: reserved affinity bits 29:12 and 7:2 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "pir_consts.svh"
module pir_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  cluster_number_pins_i,
  input  wire logic [1:0]  core_index_i,
  input  wire logic        req_valid_i,
  input  wire logic        req_write_i,
  input  wire logic        req_priv_i,
  input  wire logic        req_secure_i,
  input  wire logic [2:0]  req_opc1_i,
  input  wire logic [3:0]  req_crn_i,
  input  wire logic [3:0]  req_crm_i,
  input  wire logic [2:0]  req_opc2_i,
  input  wire logic [31:0] req_wdata_i,
  output logic             rsp_valid_o,
  output logic             rsp_undef_o,
  output logic [31:0]      rsp_rdata_o
);

  // reset release through two flip-flops
  logic [1:0]  rst_sync_q;
  logic        rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // straps are caught once, on the first edge after release
  logic        strap_done_q;
  logic [3:0]  cluster_q;
  logic [1:0]  core_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'h0;
      cluster_q    <= `PIR_ZERO4;
      core_q       <= `PIR_ZERO2;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'h1;
      cluster_q    <= cluster_number_pins_i; // see R7
      core_q       <= core_index_i;          // see R8
    end
  end

  // request decode; the secure flag takes no part, one copy serves both
  wire         req_unused_sec = req_secure_i; // see R4
  wire         dec_base       = (req_opc1_i == `PIR_OPC1_ID) && (req_crn_i == `PIR_CRN_ID);
  wire         dec_main       = dec_base && (req_crm_i == `PIR_CRM_MAIN);
  wire         dec_feat       = dec_base && (req_crm_i == `PIR_CRM_FEAT);
  wire         hit_tcm        = dec_main && (req_opc2_i == `PIR_OPC2_TCM);
  wire         hit_tlb        = dec_main && (req_opc2_i == `PIR_OPC2_TLB);
  wire         hit_aff        = dec_main && (req_opc2_i == `PIR_OPC2_AFF);  // see R9
  wire         hit_pfr0       = dec_feat && (req_opc2_i == `PIR_OPC2_PFR0); // see R10
  wire         hit_pfr1       = dec_feat && (req_opc2_i == `PIR_OPC2_PFR1); // see R10
  wire         hit_dfr0       = dec_feat && (req_opc2_i == `PIR_OPC2_DFR0); // see R10
  wire         hit_afr0       = dec_feat && (req_opc2_i == `PIR_OPC2_AFR0); // see R10

  // selection of the addressed register
  pir_pkg::pir_sel_type sel;
  assign sel = hit_tcm  ? pir_pkg::PIR_SEL_TCM  :
               hit_tlb  ? pir_pkg::PIR_SEL_TLB  :
               hit_aff  ? pir_pkg::PIR_SEL_AFF  :
               hit_pfr0 ? pir_pkg::PIR_SEL_PFR0 :
               hit_pfr1 ? pir_pkg::PIR_SEL_PFR1 :
               hit_dfr0 ? pir_pkg::PIR_SEL_DFR0 :
               hit_afr0 ? pir_pkg::PIR_SEL_AFR0 : pir_pkg::PIR_SEL_NONE;

  // privilege gate: user mode may only see the unrestricted registers
  wire         need_priv = hit_aff || hit_pfr1 || hit_dfr0; // see R3
  wire         priv_fail = need_priv && !req_priv_i;        // see R3
  // writes are ignored by the auxiliary register, refused elsewhere
  wire         wr_fail   = req_write_i && !hit_afr0;        // see R16
  wire         undef_d   = (sel == pir_pkg::PIR_SEL_NONE) || priv_fail || wr_fail;

  // fixed register images
  wire  [31:0] aff_val  = {`PIR_AFF_FMT_VAL, `PIR_AFF_UP_VAL, 18'h00000, // see R5, see R6
                           cluster_q, 6'h00, core_q};          // see R7, see R8, see R17
  wire  [31:0] pfr0_val = {16'h0000, `PIR_PFR0_ST3, `PIR_PFR0_ST2, // see R11
                           `PIR_PFR0_ST1, `PIR_PFR0_ST0};           // see R12
  wire  [31:0] pfr1_val = {20'h00000, `PIR_PFR1_MPROF,
                           `PIR_PFR1_SEC, `PIR_PFR1_PM};            // see R13
  wire  [31:0] dfr0_val = {4'h0, `PIR_DFR_PMU, `PIR_DFR_MDBG_M,
                           `PIR_DFR_MMTRC, `PIR_DFR_CPTRC,          // see R14
                           `PIR_DFR_MMDBG, `PIR_DFR_CPSDBG, `PIR_DFR_CPDBG}; // see R15

  // read mux; the zero registers simply fall to the zero image
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = `PIR_ZERO32;
    unique case (sel)
      pir_pkg::PIR_SEL_AFF:  rdata_d = aff_val;
      pir_pkg::PIR_SEL_PFR0: rdata_d = pfr0_val;
      pir_pkg::PIR_SEL_PFR1: rdata_d = pfr1_val;
      pir_pkg::PIR_SEL_DFR0: rdata_d = dfr0_val;
      pir_pkg::PIR_SEL_TCM:  rdata_d = `PIR_ZERO32; // see R1
      pir_pkg::PIR_SEL_TLB:  rdata_d = `PIR_ZERO32; // see R2
      pir_pkg::PIR_SEL_AFR0: rdata_d = `PIR_ZERO32; // see R16
      pir_pkg::PIR_SEL_NONE: rdata_d = `PIR_ZERO32;
    endcase
  end

  // answer one cycle after the request; data is zero on writes and refusals
  logic        rsp_valid_q;
  logic        rsp_undef_q;
  logic [31:0] rsp_rdata_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'h0;
      rsp_undef_q <= 1'h0;
      rsp_rdata_q <= `PIR_ZERO32;
    end else begin
      rsp_valid_q <= req_valid_i;
      rsp_undef_q <= req_valid_i && undef_d;
      rsp_rdata_q <= (req_valid_i && !undef_d && !req_write_i) ? rdata_d : `PIR_ZERO32;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_undef_o = rsp_undef_q;
  assign rsp_rdata_o = rsp_rdata_q;

  // direction of the previous request, held in a flop so the helper stays a plain net
  logic        last_write_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      last_write_q <= 1'h0;
    end else begin
      last_write_q <= req_write_i;
    end
  end

  // helper: a clean read answer of the previous request
  wire         ok_read = rsp_valid_o && !rsp_undef_o && !last_write_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  chk_tcm_reads_zero: assert property ( // see R1
    req_valid_i && !req_write_i && hit_tcm |=> rsp_valid_o && rsp_rdata_o == 32'h0000_0000
  ) else $error("tcm type register read not zero");

  chk_tlb_reads_zero: assert property ( // see R2
    req_valid_i && !req_write_i && hit_tlb |=> rsp_valid_o && !rsp_undef_o
      && rsp_rdata_o == 32'h0000_0000
  ) else $error("tlb type register read not zero");

  chk_user_mode_refused: assert property ( // see R3
    req_valid_i && !req_priv_i && (hit_aff || hit_pfr1 || hit_dfr0)
      |=> rsp_undef_o && rsp_rdata_o == 32'h0000_0000
  ) else $error("user mode reached a privileged register");

  chk_priv_mode_allowed: assert property ( // see R3
    req_valid_i && req_priv_i && !req_write_i && (hit_aff || hit_pfr1 || hit_dfr0)
      |=> rsp_valid_o && !rsp_undef_o
  ) else $error("privileged read refused");

  chk_secure_no_effect: assert property ( // see R4
    req_valid_i && !req_write_i && hit_aff && req_priv_i ##1
      req_valid_i && !req_write_i && hit_aff && req_priv_i && (req_secure_i != $past(req_secure_i))
      |=> rsp_rdata_o == $past(rsp_rdata_o)
  ) else $error("secure and non-secure reads differ");

  chk_aff_format_bit: assert property ( // see R5
    ok_read && $past(hit_aff) |-> rsp_rdata_o[31] == 1'h1
  ) else $error("affinity format bit not one");

  chk_aff_up_bit: assert property ( // see R6
    ok_read && $past(hit_aff) |-> rsp_rdata_o[30] == 1'h0
  ) else $error("affinity uniprocessor bit not zero");

  chk_aff_cluster_field: assert property ( // see R7
    ok_read && $past(hit_aff) |-> rsp_rdata_o[11:8] == cluster_q
  ) else $error("affinity cluster field wrong");

  chk_cluster_stable: assert property ( // see R7
    strap_done_q |=> $stable(cluster_q) && $stable(core_q)
  ) else $error("sampled straps changed after capture");

  chk_aff_core_field: assert property ( // see R8
    ok_read && $past(hit_aff) |-> rsp_rdata_o[1:0] == core_q
  ) else $error("affinity core index wrong");

  chk_aff_decode: assert property ( // see R9
    req_valid_i && req_priv_i && !req_write_i && req_opc1_i == 3'h0 && req_crn_i == 4'h0
      && req_crm_i == 4'h0 && req_opc2_i == 3'h5 |=> !rsp_undef_o && rsp_rdata_o[31]
  ) else $error("affinity decode failed");

  chk_feat_decode: assert property ( // see R10
    req_valid_i && !req_write_i && req_opc1_i == 3'h0 && req_crn_i == 4'h0
      && req_crm_i == 4'h1 && req_opc2_i == 3'h0 |=> !rsp_undef_o
      && rsp_rdata_o == 32'h0000_1231
  ) else $error("feature 0 decode or value wrong");

  chk_unmapped_undef: assert property ( // see R10
    req_valid_i && req_opc1_i != 3'h0 |=> rsp_valid_o && rsp_undef_o
  ) else $error("unmapped encoding not refused");

  chk_pfr0_fields: assert property ( // see R11
    ok_read && $past(hit_pfr0) |-> rsp_rdata_o[15:12] == 4'h1 && rsp_rdata_o[11:8] == 4'h2
  ) else $error("feature 0 state fields wrong");

  chk_pfr0_low_fields: assert property ( // see R12
    ok_read && $past(hit_pfr0) |-> rsp_rdata_o[31:16] == 16'h0000
      && rsp_rdata_o[7:4] == 4'h3 && rsp_rdata_o[3:0] == 4'h1
  ) else $error("feature 0 low fields wrong");

  chk_pfr1_value: assert property ( // see R13
    req_valid_i && req_priv_i && !req_write_i && hit_pfr1
      |=> !rsp_undef_o && rsp_rdata_o == 32'h0000_0011
  ) else $error("feature 1 value wrong");

  chk_dfr_upper: assert property ( // see R14
    ok_read && $past(hit_dfr0) |-> rsp_rdata_o[31:28] == 4'h0 && rsp_rdata_o[27:24] == 4'h2
      && rsp_rdata_o[23:20] == 4'h0 && rsp_rdata_o[19:16] == 4'h1 && rsp_rdata_o[15:12] == 4'h0
  ) else $error("debug feature upper fields wrong");

  chk_dfr_lower: assert property ( // see R15
    ok_read && $past(hit_dfr0) |-> rsp_rdata_o[11:0] == 12'h444
  ) else $error("debug feature lower fields wrong");

  chk_afr_write_ignored: assert property ( // see R16
    req_valid_i && req_write_i && hit_afr0 |=> rsp_valid_o && !rsp_undef_o
      ##1 (!(rsp_valid_o && !rsp_undef_o && $past(hit_afr0)) || rsp_rdata_o == 32'h0000_0000)
  ) else $error("auxiliary write not ignored");

  chk_aff_reserved: assert property ( // see R17
    ok_read && $past(hit_aff) |-> rsp_rdata_o[29:12] == 18'h00000 && rsp_rdata_o[7:2] == 6'h00
  ) else $error("affinity reserved bits not zero");

  chk_answer_latency: assert property (
    req_valid_i |=> rsp_valid_o ##0 $past(req_valid_i) ##1 (rsp_valid_o == $past(req_valid_i))
  ) else $error("answer not one cycle after request");

  // answers stand one cycle only; a quiet request slot leaves every output low
  chk_idle_quiet: assert property (
    !req_valid_i |=> !rsp_valid_o && !rsp_undef_o && rsp_rdata_o == 32'h0000_0000
  ) else $error("answer outputs not quiet without request");

  chk_undef_with_valid: assert property (
    rsp_undef_o |-> rsp_valid_o
  ) else $error("refusal without answer strobe");

  chk_refused_data_zero: assert property ( // see R3
    rsp_undef_o |-> rsp_rdata_o == 32'h0000_0000
  ) else $error("refused answer carries data");

  chk_write_refused: assert property ( // see R16
    req_valid_i && req_write_i && !hit_afr0
      |=> rsp_valid_o && rsp_undef_o && rsp_rdata_o == 32'h0000_0000
  ) else $error("write to read-only register not refused");

  chk_afr_reads_zero: assert property ( // see R16
    req_valid_i && !req_write_i && hit_afr0
      |=> rsp_valid_o && !rsp_undef_o && rsp_rdata_o == 32'h0000_0000
  ) else $error("auxiliary register read not zero");

  chk_pfr0_user_ok: assert property ( // see R3
    req_valid_i && !req_priv_i && !req_write_i && hit_pfr0 |=> rsp_valid_o && !rsp_undef_o
  ) else $error("user read of feature 0 refused");

  chk_dfr_value: assert property ( // see R14
    req_valid_i && req_priv_i && !req_write_i && hit_dfr0
      |=> !rsp_undef_o && rsp_rdata_o == 32'h0201_0444
  ) else $error("debug feature value wrong");

  chk_strap_capture: assert property ( // see R7
    !strap_done_q |=> cluster_q == $past(cluster_number_pins_i) && core_q == $past(core_index_i)
  ) else $error("straps not captured after release");

endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the processor identification register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i;
  logic        rst_n_i;
  logic [3:0]  cluster_number_pins_i;
  logic [1:0]  core_index_i;
  logic        req_valid_i;
  logic        req_write_i;
  logic        req_priv_i;
  logic        req_secure_i;
  logic [2:0]  req_opc1_i;
  logic [3:0]  req_crn_i;
  logic [3:0]  req_crm_i;
  logic [2:0]  req_opc2_i;
  logic [31:0] req_wdata_i;
  logic        rsp_valid_o;
  logic        rsp_undef_o;
  logic [31:0] rsp_rdata_o;
  int          n_mismatch;
  int          cmp_count;
  // lookup of the seven mapped places: tcm, tlb, affinity, feat0, feat1, debug, aux
  logic [3:0]  crm_t [7] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1};
  logic [2:0]  op2_t [7] = '{3'h2, 3'h3, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3};
  logic [31:0] val_t [7] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_1231,
                             32'h0000_0011, 32'h0201_0444, 32'h0000_0000};
  logic        prv_t [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  pir_regs u_pir_regs (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .cluster_number_pins_i (cluster_number_pins_i),
    .core_index_i          (core_index_i),
    .req_valid_i           (req_valid_i),
    .req_write_i           (req_write_i),
    .req_priv_i            (req_priv_i),
    .req_secure_i          (req_secure_i),
    .req_opc1_i            (req_opc1_i),
    .req_crn_i             (req_crn_i),
    .req_crm_i             (req_crm_i),
    .req_opc2_i            (req_opc2_i),
    .req_wdata_i           (req_wdata_i),
    .rsp_valid_o           (rsp_valid_o),
    .rsp_undef_o           (rsp_undef_o),
    .rsp_rdata_o           (rsp_rdata_o)
  );

  // free-running core clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one request: valid stays high so calls in a row are back to back
  task automatic acc(input logic wr, input logic pv, input logic sc, input logic [2:0] o1,
                     input logic [3:0] cn, input logic [3:0] cm, input logic [2:0] o2,
                     input logic ud, input logic [31:0] rd);
    req_valid_i  = 1'b1;
    req_write_i  = wr;
    req_priv_i   = pv;
    req_secure_i = sc;
    req_opc1_i   = o1;
    req_crn_i    = cn;
    req_crm_i    = cm;
    req_opc2_i   = o2;
    req_wdata_i  = 32'hffff_ffff;
    @(posedge clk_i);
    #1;
    chk("rsp_valid", {31'h0, rsp_valid_o}, 32'h1);
    chk("rsp_undef", {31'h0, rsp_undef_o}, {31'h0, ud});
    chk("rsp_rdata", rsp_rdata_o, rd);
  endtask

  // no request: the answer must have dropped after its single cycle
  task automatic idle();
    req_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk("idle_valid", {31'h0, rsp_valid_o}, 32'h0);
    chk("idle_rdata", rsp_rdata_o, 32'h0);
    chk("idle_undef", {31'h0, rsp_undef_o}, 32'h0);
  endtask

  // reset with given straps; first request is taken at edge 4 after release
  task automatic do_reset(input logic [3:0] cl, input logic [1:0] ci);
    rst_n_i               = 1'b0;
    req_valid_i           = 1'b0;
    cluster_number_pins_i = cl;
    core_index_i          = ci;
    repeat (2) @(posedge clk_i);
    #1;
    chk("reset_valid", {31'h0, rsp_valid_o}, 32'h0);
    rst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // every mapped place, both security states, both privilege levels
  task automatic sweep(input logic [3:0] cl, input logic [1:0] ci);
    logic ud;
    val_t[2] = {1'b1, 1'b0, 18'h0, cl, 6'h0, ci};
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < 7; i++) begin
          ud = (p == 0) && prv_t[i];
          acc(1'b0, p[0], s[0], 3'h0, 4'h0, crm_t[i], op2_t[i], ud, ud ? 32'h0 : val_t[i]);
        end
      end
    end
    idle();
    $display("test sweep done");
  endtask

  // hang guard
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    n_mismatch   = 0;
    cmp_count    = 0;
    req_write_i  = 1'b0;
    req_priv_i   = 1'b0;
    req_secure_i = 1'b0;
    req_opc1_i   = 3'h0;
    req_crn_i    = 4'h0;
    req_crm_i    = 4'h0;
    req_opc2_i   = 3'h0;
    req_wdata_i  = 32'h0;
    do_reset(4'ha, 2'h3);
    sweep(4'ha, 2'h3);
    // straps moved after capture must not show
    cluster_number_pins_i = 4'h6;
    core_index_i          = 2'h1;
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h0, 3'h5, 1'b0, 32'h8000_0a03);
    acc(1'b0, 1'b1, 1'b1, 3'h0, 4'h0, 4'h0, 3'h5, 1'b0, 32'h8000_0a03);
    idle();
    $display("test strap hold done");
    // aux write ignored, other writes refused, aux still zero
    acc(1'b1, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h3, 1'b0, 32'h0);
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h3, 1'b0, 32'h0);
    acc(1'b1, 1'b1, 1'b0, 3'h0, 4'h0, 4'h1, 3'h0, 1'b1, 32'h0);
    acc(1'b1, 1'b1, 1'b1, 3'h0, 4'h0, 4'h0, 3'h5, 1'b1, 32'h0);
    idle();
    $display("test writes done");
    // near misses of the mapped encodings
    acc(1'b0, 1'b1, 1'b0, 3'h1, 4'h0, 4'h0, 3'h5, 1'b1, 32'h0);
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h1, 4'h1, 3'h0, 1'b1, 32'h0);
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h0, 3'h4, 1'b1, 32'h0);
    acc(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'h2, 3'h0, 1'b1, 32'h0);
    idle();
    $display("test unmapped done");
    // second reset with other straps
    do_reset(4'h5, 2'h0);
    sweep(4'h5, 2'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
